/* File: cmp_pkg.sv */
// Package for the comparator output logic: constants and shared types
package cmp_pkg;
    // -------------------------------------------------------------
    // Sizes and reset values
    // -------------------------------------------------------------
    localparam int         CHANNEL_WIDTH  = 3;
    localparam int         INSTR_DIV      = 4;
    localparam logic [2:0] CHANNEL_RESET  = 3'h0;
    localparam logic [1:0] DIV_RESET      = 2'h0;
    // Positive channel codes
    localparam logic [2:0] POS_PIN        = 3'h0;
    localparam logic [2:0] POS_DAC        = 3'h1;
    localparam logic [2:0] POS_FIXED_REF  = 3'h2;
    localparam logic [2:0] POS_GROUND     = 3'h3;
    // Negative channel codes
    localparam logic [2:0] NEG_PIN        = 3'h0;
    localparam logic [2:0] NEG_FIXED_REF  = 3'h1;
    localparam logic [2:0] NEG_GROUND     = 3'h2;
    // Analog switch selects: one-hot, all zero means disconnected
    typedef logic [3:0] pos_route_t;
    typedef logic [2:0] neg_route_t;
endpackage

/* File: cmp_link_if.sv */
// Interface joining the software side and the comparator end
`timescale 1ns/1ps
interface cmp_link_if;
    logic       comparator_enable;
    logic       output_invert;
    logic       hysteresis_enable;
    logic       timer_sync_enable;
    logic       rise_irq_enable;
    logic       fall_irq_enable;
    logic [2:0] positive_channel_select;
    logic [2:0] negative_channel_select;
    logic       irq_clear;
    logic       comparator_result;
    logic       shared_result_mirror;
    logic       comparator_irq_flag;
    modport device (
        input  comparator_enable, output_invert, hysteresis_enable,
        input  timer_sync_enable, rise_irq_enable, fall_irq_enable,
        input  positive_channel_select, negative_channel_select,
        input  irq_clear,
        output comparator_result, shared_result_mirror,
        output comparator_irq_flag
    );
    modport host (
        output comparator_enable, output_invert, hysteresis_enable,
        output timer_sync_enable, rise_irq_enable, fall_irq_enable,
        output positive_channel_select, negative_channel_select,
        output irq_clear,
        input  comparator_result, shared_result_mirror,
        input  comparator_irq_flag
    );
endinterface

/* File: cmp_device.sv */
// Comparator end: latching, polarity, sync, edges and flag
`timescale 1ns/1ps
module cmp_device (
    input  wire logic           clk_sys_in,
    input  wire logic           reset_n_in,
    cmp_link_if.device          link,
    input  wire logic           analog_above_in,
    input  wire logic           timer_clk_in,
    input  wire logic           shutdown_source_enable_in,
    input  wire logic           sleep_in,
    input  wire logic           timer_halted_in,
    output logic                timer_gate_out,
    output logic                pin_result_out,
    output logic                shutdown_out,
    output logic                wake_out,
    output logic                hysteresis_on_out,
    output logic                analog_power_out,
    output cmp_pkg::pos_route_t pos_route_out,
    output cmp_pkg::neg_route_t neg_route_out
);
    // -------------------------------------------------------------
    // Local constants
    // -------------------------------------------------------------
    // Divider count on which an instruction cycle ends
    localparam int         INSTR_DIV_M1 = cmp_pkg::INSTR_DIV - 1;
    localparam logic [1:0] DIV_LAST     = 2'(INSTR_DIV_M1);

    // -------------------------------------------------------------
    // Declarations
    // -------------------------------------------------------------
    // Synchroniser state: bit 0 analog result, bit 1 timer clock
    logic [1:0] async_in;
    logic [1:0] meta_reg;
    logic [1:0] meta_next;
    logic [1:0] sync_reg;
    logic [1:0] sync_next;
    logic       cmp_synced;
    logic       tclk_synced;
    // Instruction cycle and latched result state
    logic [1:0] div_reg;
    logic [1:0] div_next;
    logic       latched_reg;
    logic       latched_next;
    logic       prev_reg;
    logic       prev_next;
    // Timer sync copy and interrupt flag state
    logic       tclk_prev_reg;
    logic       tclk_prev_next;
    logic       tsync_reg;
    logic       tsync_next;
    logic       flag_reg;
    logic       flag_next;
    // Combinational helpers
    logic       tick;
    logic       raw;
    logic       adjusted;
    logic       rise_ev;
    logic       fall_ev;
    logic       tfall;
    logic       ext_val;

    // -------------------------------------------------------------
    // Input synchronisers
    // -------------------------------------------------------------
    // Both pins are asynchronous; only the second stage is read
    assign async_in    = {timer_clk_in, analog_above_in};
    assign cmp_synced  = sync_reg[0];
    assign tclk_synced = sync_reg[1];

    always_comb begin
        meta_next = async_in;
        sync_next = meta_reg;
    end

    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
            meta_reg <= 2'h0;
            sync_reg <= 2'h0;
        end else begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
        end
    end

    // -------------------------------------------------------------
    // Instruction cycle divider
    // -------------------------------------------------------------
    // Tick marks the last clock of each instruction cycle
    always_comb begin
        tick     = (div_reg == DIV_LAST);
        div_next = tick ? cmp_pkg::DIV_RESET : div_reg + 2'h1;
    end

    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
            div_reg <= cmp_pkg::DIV_RESET;
        end else begin
            div_reg <= div_next;
        end
    end

    // -------------------------------------------------------------
    // Result latch and edge detectors
    // -------------------------------------------------------------
    // Edges lag the latched result by one instruction cycle
    always_comb begin
        // Disabled comparator reads low
        raw          = link.comparator_enable & cmp_synced;
        // Invert applies even when disabled, so toggles make edges
        adjusted     = raw ^ link.output_invert;
        latched_next = tick ? adjusted : latched_reg;
        prev_next    = tick ? latched_reg : prev_reg;
        // Compare present and previous latched samples
        rise_ev      = tick & latched_reg & ~prev_reg;
        fall_ev      = tick & ~latched_reg & prev_reg;
    end

    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
            latched_reg <= 1'b0;
            prev_reg    <= 1'b0;
        end else begin
            latched_reg <= latched_next;
            prev_reg    <= prev_next;
        end
    end

    // -------------------------------------------------------------
    // Timer clock falling edge and synced copy
    // -------------------------------------------------------------
    // Edge seen two clocks late; timer clock must be slower than this
    always_comb begin
        tclk_prev_next = tclk_synced;
        // Timer clock given is already prescaled
        tfall          = tclk_prev_reg & ~tclk_synced;
        // Halted timer in sleep freezes the synced copy
        tsync_next     = (tfall & ~(sleep_in & timer_halted_in)) ?
                         adjusted : tsync_reg;
    end

    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
            tclk_prev_reg <= 1'b0;
            tsync_reg     <= 1'b0;
        end else begin
            tclk_prev_reg <= tclk_prev_next;
            tsync_reg     <= tsync_next;
        end
    end

    // -------------------------------------------------------------
    // Interrupt flag
    // -------------------------------------------------------------
    // Clear is a level: while it is held the flag only rises for one cycle on a set
    always_comb begin
        // Set beats a same-cycle clear
        flag_next = (rise_ev & link.rise_irq_enable) |
                    (fall_ev & link.fall_irq_enable) |
                    (flag_reg & ~link.irq_clear);
    end

    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
            flag_reg <= 1'b0;
        end else begin
            flag_reg <= flag_next;
        end
    end

    // -------------------------------------------------------------
    // Outputs
    // -------------------------------------------------------------
    // Pin path is not latched unless synced; the timer-synced copy tsync_reg is used
    assign ext_val = link.timer_sync_enable ? tsync_reg : adjusted;
    assign timer_gate_out       = ext_val;
    assign pin_result_out       = ext_val;
    assign shutdown_out         = ext_val & shutdown_source_enable_in;
    assign link.comparator_result    = latched_reg;
    assign link.shared_result_mirror = latched_reg;
    assign link.comparator_irq_flag  = flag_reg;
    // Flag wakes from sleep; irq enable gating is the host's job
    assign wake_out             = flag_reg & sleep_in;
    assign hysteresis_on_out    = link.hysteresis_enable &
                                  link.comparator_enable;
    assign analog_power_out     = link.comparator_enable;

    // -------------------------------------------------------------
    // Analog switch routing
    // -------------------------------------------------------------
    // Codes without a source leave the input open
    always_comb begin
        pos_route_out = '0;
        neg_route_out = '0;
        if (link.comparator_enable) begin
            unique case (link.positive_channel_select)
                cmp_pkg::POS_PIN:       pos_route_out = 4'h1;
                cmp_pkg::POS_DAC:       pos_route_out = 4'h2;
                cmp_pkg::POS_FIXED_REF: pos_route_out = 4'h4;
                cmp_pkg::POS_GROUND:    pos_route_out = 4'h8;
                default:                pos_route_out = 4'h0;
            endcase
            unique case (link.negative_channel_select)
                cmp_pkg::NEG_PIN:       neg_route_out = 3'h1;
                cmp_pkg::NEG_FIXED_REF: neg_route_out = 3'h2;
                cmp_pkg::NEG_GROUND:    neg_route_out = 3'h4;
                default:                neg_route_out = 3'h0;
            endcase
        end
    end
endmodule

/* File: cmp_host.sv */
// Software-side end: holds control bits and interrupt gating
`timescale 1ns/1ps
module cmp_host (
    input  wire logic       clk_sys_in,
    input  wire logic       reset_n_in,
    cmp_link_if.host        link,
    input  wire logic       ctrl_write_in,
    input  wire logic [6:0] ctrl_bits_in,
    input  wire logic [2:0] pos_sel_in,
    input  wire logic [2:0] neg_sel_in,
    input  wire logic       irq_clear_in,
    input  wire logic       comparator_irq_enable_in,
    input  wire logic       peripheral_irq_gate_in,
    input  wire logic       global_irq_gate_in,
    output logic            result_out,
    output logic [1:0]      result_summary_reg_out,
    output logic            irq_out
);
    // -------------------------------------------------------------
    // Control state
    // -------------------------------------------------------------
    // ctrl_bits: en, invert, hyst, sync, rise, fall, spare
    logic [6:0] ctrl_reg, ctrl_next;
    logic [2:0] pos_reg, pos_next, neg_reg, neg_next;
    logic       res_reg, res_next;

    always_comb begin
        ctrl_next = ctrl_write_in ? ctrl_bits_in : ctrl_reg;
        pos_next  = ctrl_write_in ? pos_sel_in : pos_reg;
        neg_next  = ctrl_write_in ? neg_sel_in : neg_reg;
        res_next  = link.comparator_result;
    end

    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
            ctrl_reg <= 7'h00;
            pos_reg  <= cmp_pkg::CHANNEL_RESET;
            neg_reg  <= cmp_pkg::CHANNEL_RESET;
            res_reg  <= 1'b0;
        end else begin
            ctrl_reg <= ctrl_next;
            pos_reg  <= pos_next;
            neg_reg  <= neg_next;
            res_reg  <= res_next;
        end
    end

    assign link.comparator_enable       = ctrl_reg[6];
    assign link.output_invert           = ctrl_reg[5];
    assign link.hysteresis_enable       = ctrl_reg[4];
    assign link.timer_sync_enable       = ctrl_reg[3];
    assign link.rise_irq_enable         = ctrl_reg[2];
    assign link.fall_irq_enable         = ctrl_reg[1];
    assign link.positive_channel_select = pos_reg;
    assign link.negative_channel_select = neg_reg;
    // Direction bit for the pin lives in the port block
    assign link.irq_clear               = irq_clear_in;
    assign result_out             = res_reg;
    assign result_summary_reg_out = {1'b0, link.shared_result_mirror};
    assign irq_out = link.comparator_irq_flag & comparator_irq_enable_in &
                     peripheral_irq_gate_in & global_irq_gate_in;
endmodule

/* File: comparator_output_logic_checker.sv */
// Checker watching the link between the software side and comparator
`timescale 1ns/1ps
module comparator_output_logic_checker (
    input wire logic clk_sys_in,
    input wire logic reset_n_in,
    input wire logic comparator_enable,
    input wire logic output_invert,
    input wire logic rise_irq_enable,
    input wire logic fall_irq_enable,
    input wire logic irq_clear,
    input wire logic comparator_result,
    input wire logic shared_result_mirror,
    input wire logic comparator_irq_flag
);
    // ------------------------------------------------------------
    // Link properties
    // ------------------------------------------------------------
    wire logic edge_en = rise_irq_enable | fall_irq_enable;
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!reset_n_in);
    property p_mirror; shared_result_mirror == comparator_result; endproperty
    a_mirror: assert property (p_mirror) else $error("mirror differs");
    property p_sticky;
        comparator_irq_flag && !irq_clear |=> comparator_irq_flag;
    endproperty
    a_sticky: assert property (p_sticky) else $error("flag lost");
    // Enable may be dropped one cycle before the flag lands
    property p_cause;
        $rose(comparator_irq_flag) |-> $past(edge_en) || $past(edge_en, 2);
    endproperty
    a_cause: assert property (p_cause) else $error("flag unasked");
    property p_tick;
        $changed(comparator_result) |=> $stable(comparator_result)[*3];
    endproperty
    a_tick: assert property (p_tick) else $error("result not ticked");
    property p_off;
        (!comparator_enable && $stable(output_invert))[*8]
            |-> comparator_result == output_invert;
    endproperty
    a_off: assert property (p_off) else $error("disabled value");
    property p_rise;
        $rose(comparator_result) && rise_irq_enable
            |-> ##[0:6] comparator_irq_flag;
    endproperty
    a_rise: assert property (p_rise) else $error("rise missed");
    property p_fall;
        $fell(comparator_result) && fall_irq_enable
            |-> ##[0:6] comparator_irq_flag;
    endproperty
    a_fall: assert property (p_fall) else $error("fall missed");
    property p_clear;
        (irq_clear && $stable(comparator_result))[*8]
            |-> !comparator_irq_flag;
    endproperty
    a_clear: assert property (p_clear) else $error("clear ignored");
endmodule

/* File: comparator_output_logic_tb.sv */
// Testbench joining both comparator ends across their link
`timescale 1ns/1ps
module comparator_output_logic_tb;
    // ------------------------------------------------------------
    // Signals and instances
    // ------------------------------------------------------------
    logic clk_sys_in = 1'b0, reset_n_in = 1'b0, an = 1'b0, tclk = 1'b0;
    logic shut_en = 1'b0, sleep = 1'b0, halted = 1'b0, wr = 1'b0;
    logic clr = 1'b0, ie = 1'b0, pg = 1'b0, gg = 1'b0;
    logic [6:0] bits = 7'h00;
    logic [2:0] pos = 3'h0, neg = 3'h0;
    logic gate, pin, shut, wake, hyst_on, pwr, res, irq;
    logic [1:0] summ;
    cmp_pkg::pos_route_t pos_r;
    cmp_pkg::neg_route_t neg_r;
    int failures = 0, n_compared = 0;
    cmp_link_if link ();
    cmp_device u_cmp_device (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
        .link(link.device), .analog_above_in(an), .timer_clk_in(tclk),
        .shutdown_source_enable_in(shut_en), .sleep_in(sleep),
        .timer_halted_in(halted), .timer_gate_out(gate),
        .pin_result_out(pin), .shutdown_out(shut), .wake_out(wake),
        .hysteresis_on_out(hyst_on), .analog_power_out(pwr),
        .pos_route_out(pos_r), .neg_route_out(neg_r));
    cmp_host u_cmp_host (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
        .link(link.host), .ctrl_write_in(wr), .ctrl_bits_in(bits),
        .pos_sel_in(pos), .neg_sel_in(neg), .irq_clear_in(clr),
        .comparator_irq_enable_in(ie), .peripheral_irq_gate_in(pg),
        .global_irq_gate_in(gg), .result_out(res),
        .result_summary_reg_out(summ), .irq_out(irq));
    comparator_output_logic_checker u_comparator_output_logic_checker (
        .clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
        .comparator_enable(link.comparator_enable),
        .output_invert(link.output_invert),
        .rise_irq_enable(link.rise_irq_enable),
        .fall_irq_enable(link.fall_irq_enable), .irq_clear(link.irq_clear),
        .comparator_result(link.comparator_result),
        .shared_result_mirror(link.shared_result_mirror),
        .comparator_irq_flag(link.comparator_irq_flag));
    initial forever #50 clk_sys_in = ~clk_sys_in;
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [3:0] route(logic en, logic [2:0] s, int n);
        return (en && s < n) ? 4'h1 << s : 4'h0;
    endfunction
    task automatic check(input logic [3:0] seen, input logic [3:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic results();
        $display("Compared %0d, failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys_in);
        #1;
    endtask
    task automatic set(input logic [6:0] b, input logic [2:0] p, q,
                       input logic a);
        @(posedge clk_sys_in);
        bits <= b;
        pos <= p;
        neg <= q;
        an <= a;
        shut_en <= 1'($urandom);
        wr <= 1'b1;
        @(posedge clk_sys_in);
        wr <= 1'b0;
    endtask
    task automatic clear();
        @(posedge clk_sys_in);
        clr <= 1'b1;
        @(posedge clk_sys_in);
        clr <= 1'b0;
    endtask
    // Polls every cycle so a one-cycle flag is still seen
    task automatic wait_flag(input logic e);
        int i;
        for (i = 0; i < 20; i++) begin
            cyc(1);
            if (link.comparator_irq_flag === e) break;
        end
        check(link.comparator_irq_flag, e);
        if (i == 20) results();
    endtask
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        logic e, v, h, a, x;
        logic [2:0] p, q;
        int k;
        void'($urandom(5));
        repeat (4) @(posedge clk_sys_in);
        reset_n_in <= 1'b1;
        for (k = 0; k < 24; k++) begin
            e = (k < 5) ? 1'b1 : 1'($urandom);
            {v, h, a} = 3'($urandom);
            p = (k < 5) ? 3'(k) : 3'($urandom);
            q = 3'(k);
            x = (e & a) ^ v;
            set({e, v, h, 4'h0}, p, q, a);
            cyc(12);
            check(res, x);
            check(summ, {1'b0, x});
            check(gate, x);
            check(pin, x);
            check(shut, x & shut_en);
            check(pos_r, route(e, p, 4));
            check(neg_r, route(e, q, 3));
            check(pwr, e);
            check(hyst_on, h & e);
        end
        set(7'h48, 3'h0, 3'h0, 1'b1);
        tclk <= 1'b1;
        cyc(8);
        @(posedge clk_sys_in);
        tclk <= 1'b0;
        cyc(8);
        check(gate, 1'b1);
        @(posedge clk_sys_in);
        tclk <= 1'b1;
        set(7'h48, 3'h0, 3'h0, 1'b0);
        cyc(12);
        check(res, 1'b0);
        check(gate, 1'b1);
        @(posedge clk_sys_in);
        tclk <= 1'b0;
        cyc(8);
        check(gate, 1'b0);
        check(pin, 1'b0);
        @(posedge clk_sys_in);
        {ie, pg, gg, sleep} <= 4'hf;
        set(7'h44, 3'h0, 3'h0, 1'b0);
        cyc(12);
        clear();
        wait_flag(1'b0);
        set(7'h44, 3'h0, 3'h0, 1'b1);
        wait_flag(1'b1);
        cyc(2);
        check(irq, 1'b1);
        check(wake, 1'b1);
        clear();
        wait_flag(1'b0);
        set(7'h44, 3'h0, 3'h0, 1'b0);
        cyc(12);
        check(link.comparator_irq_flag, 1'b0);
        set(7'h42, 3'h0, 3'h0, 1'b1);
        cyc(12);
        check(link.comparator_irq_flag, 1'b0);
        set(7'h42, 3'h0, 3'h0, 1'b0);
        wait_flag(1'b1);
        @(posedge clk_sys_in);
        clr <= 1'b1;
        set(7'h46, 3'h0, 3'h0, 1'b1);
        wait_flag(1'b1);
        @(posedge clk_sys_in);
        clr <= 1'b0;
        set(7'h04, 3'h0, 3'h0, 1'b0);
        cyc(12);
        clear();
        wait_flag(1'b0);
        set(7'h24, 3'h0, 3'h0, 1'b0);
        wait_flag(1'b1);
        @(posedge clk_sys_in);
        ie <= 1'b0;
        cyc(1);
        check(irq, 1'b0);
        check(wake, 1'b1);
        @(posedge clk_sys_in);
        clr <= 1'b1;
        cyc(10);
        check(link.comparator_irq_flag, 1'b0);
        @(posedge clk_sys_in);
        clr <= 1'b0;
        halted <= 1'b1;
        set(7'h48, 3'h0, 3'h0, 1'b1);
        tclk <= 1'b1;
        cyc(8);
        @(posedge clk_sys_in);
        tclk <= 1'b0;
        cyc(8);
        check(gate, 1'b0);
        @(posedge clk_sys_in);
        halted <= 1'b0;
        tclk <= 1'b1;
        cyc(8);
        @(posedge clk_sys_in);
        tclk <= 1'b0;
        cyc(8);
        check(gate, 1'b1);
        results();
    end
endmodule
